// ---- rtl/gpoe_cfg.svh ----
`ifndef GPOE_CFG_SVH
`define GPOE_CFG_SVH
`define GPOE_ADDR_W 8
`define GPOE_DATA_W 32
`define GPOE_HI_W 8
`define GPOE_STRAP_W 6
`define GPOE_OFS_OUT_LO 8'h04
`define GPOE_OFS_OUT_SET_LO 8'h08
`define GPOE_OFS_OUT_CLR_LO 8'h0C
`define GPOE_OFS_OUT_HI 8'h10
`define GPOE_OFS_OUT_SET_HI 8'h14
`define GPOE_OFS_OUT_CLR_HI 8'h18
`define GPOE_OFS_EN_LO 8'h20
`define GPOE_OFS_EN_SET_LO 8'h24
`define GPOE_OFS_EN_CLR_LO 8'h28
`define GPOE_OFS_EN_HI 8'h2C
`define GPOE_OFS_EN_SET_HI 8'h30
`define GPOE_OFS_EN_CLR_HI 8'h34
`define GPOE_OFS_STRAP 8'h38
`define GPOE_RST_LO 32'h00000000
`define GPOE_RST_HI 8'h00
`define GPOE_RST_STRAP 6'h00
`endif

// ---- rtl/gpoe_pkg.sv ----
`include "gpoe_cfg.svh"
package gpoe_pkg;
    typedef logic [`GPOE_ADDR_W-1:0] gpoe_addr_t;
    typedef logic [`GPOE_DATA_W-1:0] gpoe_word_t;
    typedef logic [`GPOE_HI_W-1:0] gpoe_hi_t;
    typedef logic [`GPOE_STRAP_W-1:0] gpoe_strap_t;
    // Strap capture progress after reset release
    typedef enum logic [1:0] {
        GPOE_CAP_WAIT = 2'b00,
        GPOE_CAP_TAKE = 2'b01,
        GPOE_CAP_DONE = 2'b10,
        GPOE_CAP_SETTLE = 2'b11
    } gpoe_cap_t;
endpackage : gpoe_pkg

// ---- rtl/gpoe_bank.sv ----
`include "gpoe_cfg.svh"
module gpoe_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire gpoe_pkg::gpoe_addr_t addr,
    input wire gpoe_pkg::gpoe_word_t wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output gpoe_pkg::gpoe_word_t rdata,
    // Boot selection pins, asynchronous
    input wire gpoe_pkg::gpoe_strap_t strap_pins,
    // Pad drivers
    output gpoe_pkg::gpoe_word_t pad_out_lo,
    output gpoe_pkg::gpoe_word_t pad_oe_lo,
    output gpoe_pkg::gpoe_hi_t pad_out_hi,
    output gpoe_pkg::gpoe_hi_t pad_oe_hi,
    // Register contents, for visibility
    output gpoe_pkg::gpoe_word_t out_value_lo,
    output gpoe_pkg::gpoe_word_t drive_en_lo,
    output gpoe_pkg::gpoe_hi_t out_value_hi,
    output gpoe_pkg::gpoe_hi_t drive_en_hi,
    output gpoe_pkg::gpoe_strap_t boot_select
);
    import gpoe_pkg::*;

    gpoe_word_t out_lo_r, out_lo_nxt;
    gpoe_word_t en_lo_r, en_lo_nxt;
    gpoe_hi_t out_hi_r;
    gpoe_hi_t en_hi_r;
    // High next values kept at bus width; the flop takes the low slice on purpose
    gpoe_word_t out_hi_nxt;
    gpoe_word_t en_hi_nxt;
    gpoe_strap_t strap_s1_r, strap_s2_r, strap_r;
    gpoe_cap_t cap_r;
    gpoe_word_t rdata_r;

    // Write decode, one hit per offset
    function automatic logic hit(input gpoe_addr_t a, input gpoe_addr_t ofs);
        hit = (a == ofs);
    endfunction : hit

    // Value/set/clear merge; a plain write wins over set, and set over clear, in same cycle
    function automatic gpoe_word_t merge(input gpoe_word_t cur, input gpoe_word_t d,
                                         input logic wv, input logic ws, input logic wc);
        merge = wv ? d : ws ? (cur | d) : wc ? (cur & ~d) : cur;
    endfunction : merge

    wire w_out_lo = wr_stb && hit(addr, `GPOE_OFS_OUT_LO);
    wire w_out_set_lo = wr_stb && hit(addr, `GPOE_OFS_OUT_SET_LO);
    wire w_out_clr_lo = wr_stb && hit(addr, `GPOE_OFS_OUT_CLR_LO);
    wire w_out_hi = wr_stb && hit(addr, `GPOE_OFS_OUT_HI);
    wire w_out_set_hi = wr_stb && hit(addr, `GPOE_OFS_OUT_SET_HI);
    wire w_out_clr_hi = wr_stb && hit(addr, `GPOE_OFS_OUT_CLR_HI);
    wire w_en_lo = wr_stb && hit(addr, `GPOE_OFS_EN_LO);
    wire w_en_set_lo = wr_stb && hit(addr, `GPOE_OFS_EN_SET_LO);
    wire w_en_clr_lo = wr_stb && hit(addr, `GPOE_OFS_EN_CLR_LO);
    wire w_en_hi = wr_stb && hit(addr, `GPOE_OFS_EN_HI);
    wire w_en_set_hi = wr_stb && hit(addr, `GPOE_OFS_EN_SET_HI);
    wire w_en_clr_hi = wr_stb && hit(addr, `GPOE_OFS_EN_CLR_HI);

    // Next values of the four vectors
    assign out_lo_nxt = merge(out_lo_r, wdata, w_out_lo, w_out_set_lo, w_out_clr_lo);
    assign out_hi_nxt = merge({24'h000000, out_hi_r}, wdata, w_out_hi, w_out_set_hi,
                              w_out_clr_hi);
    assign en_lo_nxt = merge(en_lo_r, wdata, w_en_lo, w_en_set_lo, w_en_clr_lo);
    assign en_hi_nxt = merge({24'h000000, en_hi_r}, wdata, w_en_hi, w_en_set_hi,
                             w_en_clr_hi);

    // Vector registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_lo_r <= `GPOE_RST_LO;
            en_lo_r <= `GPOE_RST_LO;
            out_hi_r <= `GPOE_RST_HI;
            en_hi_r <= `GPOE_RST_HI;
        end
        else
        begin
            out_lo_r <= out_lo_nxt;
            en_lo_r <= en_lo_nxt;
            out_hi_r <= out_hi_nxt[`GPOE_HI_W-1:0];
            en_hi_r <= en_hi_nxt[`GPOE_HI_W-1:0];
        end
    end

    // Strap pins pass two flops; the level is caught once, after release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_s1_r <= `GPOE_RST_STRAP;
            strap_s2_r <= `GPOE_RST_STRAP;
        end
        else
        begin
            strap_s1_r <= strap_pins;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Capture sequencer waits until the synchroniser holds real pin levels
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cap_r <= GPOE_CAP_WAIT;
            strap_r <= `GPOE_RST_STRAP;
        end
        else
        begin
            case (cap_r)
                // Two waits: the second flop holds reset zeros until the second edge
                GPOE_CAP_WAIT: cap_r <= GPOE_CAP_SETTLE;
                GPOE_CAP_SETTLE: cap_r <= GPOE_CAP_TAKE;
                GPOE_CAP_TAKE:
                begin
                    strap_r <= strap_s2_r;
                    cap_r <= GPOE_CAP_DONE;
                end
                GPOE_CAP_DONE: cap_r <= GPOE_CAP_DONE; // Writes never reach strap_r
                default: cap_r <= GPOE_CAP_WAIT;
            endcase
        end
    end

    // Read mux; set/clear and unmapped offsets read zero
    wire gpoe_word_t rd_mux =
        hit(addr, `GPOE_OFS_OUT_LO) ? out_lo_r :
        hit(addr, `GPOE_OFS_OUT_HI) ? {24'h000000, out_hi_r} :
        hit(addr, `GPOE_OFS_EN_LO) ? en_lo_r :
        hit(addr, `GPOE_OFS_EN_HI) ? {24'h000000, en_hi_r} :
        hit(addr, `GPOE_OFS_STRAP) ? {26'h0000000, strap_r} :
        32'h00000000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_r <= 32'h00000000;
        else
            rdata_r <= rd_stb ? rd_mux : 32'h00000000;
    end

    assign rdata = rdata_r;
    assign out_value_lo = out_lo_r;
    assign drive_en_lo = en_lo_r;
    assign out_value_hi = out_hi_r;
    assign drive_en_hi = en_hi_r;
    assign boot_select = strap_r;
    // Pad output enable is the enable bit; data forced low when released
    assign pad_oe_lo = en_lo_r;
    assign pad_out_lo = out_lo_r & en_lo_r;
    assign pad_oe_hi = en_hi_r;
    assign pad_out_hi = out_hi_r & en_hi_r;

    // Checks
    AST_SET_LO: assert property (@(posedge clk) disable iff (!reset_n)
        w_out_set_lo |=> ((out_lo_r & $past(wdata)) == $past(wdata)))
        else $error("low set write did not set bits");
    AST_CLR_LO: assert property (@(posedge clk) disable iff (!reset_n)
        w_out_clr_lo |=> ((out_lo_r & $past(wdata)) == 32'h00000000))
        else $error("low clear write did not clear bits");
    AST_KEEP_LO: assert property (@(posedge clk) disable iff (!reset_n)
        (w_out_set_lo || w_out_clr_lo) |=>
        ((out_lo_r & ~$past(wdata)) == ($past(out_lo_r) & ~$past(wdata))))
        else $error("low set or clear touched zero bits");
    AST_WR_HI: assert property (@(posedge clk) disable iff (!reset_n)
        w_out_hi |=> (out_hi_r == $past(wdata[7:0])))
        else $error("high value write lost");
    AST_EN_SET_HI: assert property (@(posedge clk) disable iff (!reset_n)
        w_en_set_hi |=> (en_hi_r == ($past(en_hi_r) | $past(wdata[7:0]))))
        else $error("high enable set wrong");
    AST_EN_CLR_LO: assert property (@(posedge clk) disable iff (!reset_n)
        w_en_clr_lo |=> (en_lo_r == ($past(en_lo_r) & ~$past(wdata))))
        else $error("low enable clear wrong");
    AST_READ_LO: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_stb && hit(addr, `GPOE_OFS_EN_LO) && !wr_stb) |=> (rdata == $past(en_lo_r)))
        else $error("low enable readback wrong");
    AST_READ_W1: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_stb && hit(addr, `GPOE_OFS_OUT_SET_HI)) |=> (rdata == 32'h00000000))
        else $error("set register read not zero");
    AST_STRAP_RO: assert property (@(posedge clk) disable iff (!reset_n)
        (cap_r == GPOE_CAP_DONE) |=> $stable(strap_r))
        else $error("strap value changed after capture");
    AST_PAD_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        ((pad_out_lo & ~pad_oe_lo) == 32'h00000000))
        else $error("pad data active while released");

    AST_WR_LO: assert property (@(posedge clk) disable iff (!reset_n)
        w_out_lo |=> (out_lo_r == $past(wdata)))
        else $error("low value write lost");

    AST_SET_HI: assert property (@(posedge clk) disable iff (!reset_n)
        w_out_set_hi |=> (out_hi_r == ($past(out_hi_r) | $past(wdata[7:0]))))
        else $error("high set write wrong");

    AST_CLR_HI: assert property (@(posedge clk) disable iff (!reset_n)
        w_out_clr_hi |=> (out_hi_r == ($past(out_hi_r) & ~$past(wdata[7:0]))))
        else $error("high clear write wrong");

    AST_WR_EN_LO: assert property (@(posedge clk) disable iff (!reset_n)
        w_en_lo |=> (en_lo_r == $past(wdata)))
        else $error("low enable write lost");

    AST_EN_SET_LO: assert property (@(posedge clk) disable iff (!reset_n)
        w_en_set_lo |=> (en_lo_r == ($past(en_lo_r) | $past(wdata))))
        else $error("low enable set wrong");

    AST_WR_EN_HI: assert property (@(posedge clk) disable iff (!reset_n)
        w_en_hi |=> (en_hi_r == $past(wdata[7:0])))
        else $error("high enable write lost");

    AST_EN_CLR_HI: assert property (@(posedge clk) disable iff (!reset_n)
        w_en_clr_hi |=> (en_hi_r == ($past(en_hi_r) & ~$past(wdata[7:0]))))
        else $error("high enable clear wrong");

    AST_STRAP_TAKE: assert property (@(posedge clk) disable iff (!reset_n)
        (cap_r == GPOE_CAP_TAKE) |=> (strap_r == $past(strap_s2_r)))
        else $error("strap capture wrong");

    AST_STRAP_WR: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_stb && hit(addr, `GPOE_OFS_STRAP) && cap_r == GPOE_CAP_DONE)
        |=> $stable(strap_r))
        else $error("strap write had effect");

    // Strap readback in two steps: a read after capture, then the word one cycle on
    sequence s_rd_strap;
        rd_stb && hit(addr, `GPOE_OFS_STRAP) && (cap_r == GPOE_CAP_DONE);
    endsequence
    sequence s_strap_word;
        rdata == {26'h0000000, strap_r};
    endsequence
    AST_READ_STRAP: assert property (@(posedge clk) disable iff (!reset_n)
        s_rd_strap |=> s_strap_word)
        else $error("strap readback wrong");

    AST_RD_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        !rd_stb |=> (rdata == 32'h00000000))
        else $error("read data stood too long");

    AST_RD_NO_SIDE: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_stb && !wr_stb) |=> ($stable(out_lo_r) && $stable(en_lo_r)
        && $stable(out_hi_r) && $stable(en_hi_r)))
        else $error("read changed a vector");

    AST_PAD_OFF_HI: assert property (@(posedge clk) disable iff (!reset_n)
        ((pad_out_hi & ~pad_oe_hi) == 8'h00))
        else $error("high pad data active while released");

    AST_OE_FOLLOW: assert property (@(posedge clk) disable iff (!reset_n)
        (pad_oe_lo == en_lo_r) && (pad_oe_hi == en_hi_r))
        else $error("pad enable differs from enable bits");
endmodule : gpoe_bank

// ---- verif/gpoe_bank_tb.sv ----
module gpoe_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import gpoe_pkg::*;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    gpoe_addr_t addr = 8'h00;
    gpoe_word_t wdata = 32'h00000000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    gpoe_strap_t strap_pins = 6'h2D;
    gpoe_word_t rdata, pad_out_lo, pad_oe_lo, out_value_lo, drive_en_lo;
    gpoe_hi_t pad_out_hi, pad_oe_hi, out_value_hi, drive_en_hi;
    gpoe_strap_t boot_select;
    int bad_count = 0;
    int n_compared = 0;

    gpoe_bank DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .strap_pins(strap_pins),
        .pad_out_lo(pad_out_lo), .pad_oe_lo(pad_oe_lo), .pad_out_hi(pad_out_hi),
        .pad_oe_hi(pad_oe_hi), .out_value_lo(out_value_lo), .drive_en_lo(drive_en_lo),
        .out_value_hi(out_value_hi), .drive_en_hi(drive_en_hi), .boot_select(boot_select));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task check(input gpoe_word_t seen, input gpoe_word_t exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write strobe; an idle cycle after it keeps strobes from being reassigned
    task bus_write(input gpoe_addr_t a, input gpoe_word_t d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask : bus_write

    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task bus_read_check(input gpoe_addr_t a, input gpoe_word_t exp);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 check(rdata, exp);
        @(posedge clk);
    endtask : bus_read_check

    // Value and enable registers and low pads all start cleared
    task test_reset;
        bus_read_check(8'h04, 32'h00000000);
        bus_read_check(8'h10, 32'h00000000);
        bus_read_check(8'h20, 32'h00000000);
        bus_read_check(8'h2C, 32'h00000000);
        check(pad_oe_lo | pad_out_lo, 32'h00000000);
    endtask : test_reset

    // Strap is taken once; later pin changes and writes must not disturb it
    task test_strap;
        strap_pins <= 6'h12;
        bus_write(8'h38, 32'hFFFFFFFF);
        bus_read_check(8'h38, 32'h0000002D);
        check({26'h0, boot_select}, 32'h0000002D);
    endtask : test_strap

    // Value, set and clear of one group; companions read zero without side effect
    task test_group(input gpoe_addr_t base, input gpoe_word_t mask);
        gpoe_word_t e;
        e = 32'hA5A5C33C & mask;
        bus_write(base, 32'hA5A5C33C);
        bus_read_check(base, e);
        e = (e | 32'h0F0F0F0F) & mask;
        bus_write(base + 8'h04, 32'h0F0F0F0F);
        bus_read_check(base, e);
        e = e & ~32'hF0000011;
        bus_write(base + 8'h08, 32'hF0000011);
        bus_read_check(base, e);
        bus_read_check(base + 8'h04, 32'h00000000);
        bus_read_check(base + 8'h08, 32'h00000000);
        bus_read_check(base, e);
    endtask : test_group

    // Pads follow value only where enabled
    task test_pads;
        bus_write(8'h04, 32'h12345678);
        bus_write(8'h20, 32'h0000FFFF);
        bus_write(8'h10, 32'h0000003C);
        bus_write(8'h2C, 32'h000000F0);
        check(pad_oe_lo, 32'h0000FFFF);
        check(pad_out_lo, 32'h00005678);
        check({pad_oe_hi, pad_out_hi}, 32'h0000F030);
        check({drive_en_hi, out_value_hi}, 32'h0000F03C);
        bus_write(8'h00, 32'hFFFFFFFF);
        bus_read_check(8'h00, 32'h00000000);
        check(out_value_lo, 32'h12345678);
    endtask : test_pads

    task report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        test_reset;
        test_strap;
        test_group(8'h04, 32'hFFFFFFFF);
        test_group(8'h10, 32'h000000FF);
        test_group(8'h20, 32'hFFFFFFFF);
        test_group(8'h2C, 32'h000000FF);
        test_pads;
        report_and_stop;
    end

    // Whole run needs about 120 cycles; this cuts a hang short
    initial
    begin
        #50000;
        bad_count++;
        report_and_stop;
    end
endmodule : gpoe_bank_tb
